// ===== design/accel_power_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 accelerometer power mode controller.
 Assumes a 10 MHz system clock and an upstream serial port decoder.
*/
`ifndef ACCEL_POWER_REGS_SVH
`define ACCEL_POWER_REGS_SVH

`define INACT_THR_ADDR 8'h25
`define INACT_TIME_ADDR 8'h26
`define RATE_CFG_ADDR 8'h2C
`define PWR_CTL_ADDR 8'h2D
`define STATUS_ADDR 8'h3F

`define RATE_CODE_LSB 0
`define RATE_CODE_MSB 3
`define RATE_LOW_POWER_BIT 4
`define PWR_MEASURE_BIT 3
`define PWR_AUTO_SLEEP_BIT 4
`define PWR_LINK_BIT 5
`define STAT_MEASURING_BIT 0
`define STAT_ASLEEP_BIT 1

`define INACT_THR_RST 8'h00
`define INACT_TIME_RST 8'h00
`define RATE_CFG_RST 8'h0A
`define PWR_CTL_RST 8'h00

`define RATE_CODE_MAX 4'hF
`define RATE_CODE_MIN 4'h6
`define SLEEP_RATE_CODE 4'h6
`define INACT_THR_SHIFT 4

`define CLK_PERIOD_NS 100
`define ODR_MAX_HZ 3200
`define ODR_BASE_CYCLES (1000000000 / (`CLK_PERIOD_NS * `ODR_MAX_HZ))
`define INACT_UNIT_S 1
`define INACT_UNIT_CYCLES (`INACT_UNIT_S * 1000000000 / `CLK_PERIOD_NS)

`endif

// ===== design/accel_power_pkg.sv
/*
 Types shared by the power mode controller modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package accel_power_pkg;
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_MEASURE = 2'b01,
      ST_SLEEP = 2'b11
   } pm_state_t;
   typedef logic [7:0] reg_byte_t;
   typedef logic signed [15:0] axis_t;
endpackage
`default_nettype wire

// ===== design/rate_tick_if.sv
/*
 Link between the controller and its output data rate divider.
 Assumes both ends share sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface rate_tick_if;
   logic [3:0] rate_code;
   logic run;
   logic odr_tick;
   modport gen (input rate_code, input run, output odr_tick);
   modport user (output rate_code, output run, input odr_tick);
endinterface
`default_nettype wire

// ===== design/rate_tick_gen.sv
/*
 Output data rate divider: one-cycle tick per output sample period.
 Assumes rate_code already clamped to the legal range.
*/
`timescale 1ns/100ps
`default_nettype none
`include "accel_power_regs.svh"
module rate_tick_gen #(
   parameter int BASE_CYCLES = `ODR_BASE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   rate_tick_if.gen tick_io
);
   import accel_power_pkg::*;

   logic [20:0] cnt_ff;
   logic tick_ff;

   function automatic logic [20:0] period_of(input logic [3:0] code);
      logic [3:0] sh;
      sh = `RATE_CODE_MAX - code;
      return 21'(BASE_CYCLES << sh);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Halving per code step
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !tick_io.run) begin
         cnt_ff <= 21'h000000;
         tick_ff <= 1'b0;
      end else if (cnt_ff >= period_of(tick_io.rate_code) - 21'h000001) begin
         cnt_ff <= 21'h000000;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 21'h000001;
         tick_ff <= 1'b0;
      end
   end

   assign tick_io.odr_tick = tick_ff;

   ////////////////////////////////////////////////////////////////////////
   a_rate_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick_io.run && $stable(tick_io.rate_code) && cnt_ff == period_of(tick_io.rate_code) - 21'h000001
      |=> tick_ff && cnt_ff == 21'h000000)
      else $error("rate tick not at code period");
endmodule
`default_nettype wire

// ===== design/accel_power_mode_control.sv
/*
 Power mode controller: standby, measurement and auto sleep, rate and
 reduced power selection, inactivity timing, register file.
 Assumes a decoded byte register port from the serial interface and one
 sample_valid pulse with three axis readings per conversion.
*/
`timescale 1ns/100ps
`default_nettype none
`include "accel_power_regs.svh"
module accel_power_mode_control #(
   parameter int SEC_CYCLES = `INACT_UNIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic io_supply_ok,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire accel_power_pkg::reg_byte_t reg_addr,
   input wire accel_power_pkg::reg_byte_t reg_wdata,
   output accel_power_pkg::reg_byte_t reg_rdata_ff,
   output logic reg_rvalid_ff,
   input wire logic sample_valid,
   input wire accel_power_pkg::axis_t accel_x,
   input wire accel_power_pkg::axis_t accel_y,
   input wire accel_power_pkg::axis_t accel_z,
   output logic sensing_on_ff,
   output logic asleep_ff,
   output logic reduced_power_ff,
   output logic sample_req_ff,
   output logic buffer_wr_ff
);
   import accel_power_pkg::*;

   reg_byte_t thr_ff;
   reg_byte_t time_ff;
   reg_byte_t rate_ff;
   reg_byte_t pwr_ff;
   reg_byte_t nxt_rdata;
   pm_state_t state_ff;
   pm_state_t nxt_state;
   logic [23:0] sec_cnt_ff;
   logic [7:0] quiet_secs_ff;
   logic lp_phase_ff;
   logic acc_wr;
   logic acc_rd;
   logic measure_bit;
   logic armed;
   logic active_sample;
   logic timeout;
   logic [3:0] code_sel;

   rate_tick_if tick_io ();

   function automatic logic exceeds(input axis_t a, input reg_byte_t thr);
      logic [15:0] mag;
      mag = a[15] ? 16'(-a) : 16'(a);
      return mag > (16'(thr) << `INACT_THR_SHIFT);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register port
   assign acc_wr = reg_wr_en && io_supply_ok;
   assign acc_rd = reg_rd_en && io_supply_ok;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         thr_ff <= `INACT_THR_RST;
         time_ff <= `INACT_TIME_RST;
         rate_ff <= `RATE_CFG_RST;
         pwr_ff <= `PWR_CTL_RST;
      end else if (acc_wr) begin
         unique case (reg_addr)
            `INACT_THR_ADDR: thr_ff <= reg_wdata;
            `INACT_TIME_ADDR: time_ff <= reg_wdata;
            `RATE_CFG_ADDR: rate_ff <= reg_wdata;
            `PWR_CTL_ADDR: pwr_ff <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      nxt_rdata = 8'h00;
      unique case (reg_addr)
         `INACT_THR_ADDR: nxt_rdata = thr_ff;
         `INACT_TIME_ADDR: nxt_rdata = time_ff;
         `RATE_CFG_ADDR: nxt_rdata = rate_ff;
         `PWR_CTL_ADDR: nxt_rdata = pwr_ff;
         `STATUS_ADDR: begin
            nxt_rdata[`STAT_MEASURING_BIT] = sensing_on_ff;
            nxt_rdata[`STAT_ASLEEP_BIT] = asleep_ff;
         end
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= acc_rd;
         if (acc_rd) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Inactivity detection
   // Measure bit position
   assign measure_bit = pwr_ff[`PWR_MEASURE_BIT];
   assign armed = (state_ff == ST_MEASURE) && pwr_ff[`PWR_AUTO_SLEEP_BIT] && pwr_ff[`PWR_LINK_BIT];
   assign active_sample = sample_valid &&
      (exceeds(accel_x, thr_ff) || exceeds(accel_y, thr_ff) || exceeds(accel_z, thr_ff));
   assign timeout = armed && !active_sample && (quiet_secs_ff >= time_ff);

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !armed || active_sample) begin
         sec_cnt_ff <= 24'h000000;
         quiet_secs_ff <= 8'h00;
      end else if (sec_cnt_ff == 24'(SEC_CYCLES - 1)) begin
         sec_cnt_ff <= 24'h000000;
         if (quiet_secs_ff != 8'hFF) begin
            quiet_secs_ff <= quiet_secs_ff + 8'h01;
         end
      end else begin
         sec_cnt_ff <= sec_cnt_ff + 24'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode state machine
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_STANDBY: if (measure_bit) nxt_state = ST_MEASURE;
         ST_MEASURE: begin
            if (!measure_bit) nxt_state = ST_STANDBY;
            else if (timeout) nxt_state = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (!measure_bit) nxt_state = ST_STANDBY;
            else if (!pwr_ff[`PWR_AUTO_SLEEP_BIT] || (active_sample && pwr_ff[`PWR_LINK_BIT])) begin
               nxt_state = ST_MEASURE;
            end
         end
         default: nxt_state = ST_STANDBY;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_ff <= ST_STANDBY;
         sensing_on_ff <= 1'b0;
         asleep_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sensing_on_ff <= (nxt_state != ST_STANDBY);
         asleep_ff <= (nxt_state == ST_SLEEP);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sampling rate
   // Clamp code to table range
   always_comb begin
      code_sel = rate_ff[`RATE_CODE_MSB:`RATE_CODE_LSB];
      if (state_ff == ST_SLEEP) code_sel = `SLEEP_RATE_CODE;
      else if (code_sel < `RATE_CODE_MIN) code_sel = `RATE_CODE_MIN;
   end

   assign tick_io.rate_code = code_sel;
   assign tick_io.run = (state_ff != ST_STANDBY);

   rate_tick_gen u_rate_tick_gen (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick_io(tick_io)
   );

   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_ff == ST_STANDBY) begin
         lp_phase_ff <= 1'b0;
         sample_req_ff <= 1'b0;
      end else begin
         if (tick_io.odr_tick) lp_phase_ff <= !lp_phase_ff;
         sample_req_ff <= tick_io.odr_tick && (!rate_ff[`RATE_LOW_POWER_BIT] || lp_phase_ff);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reduced_power_ff <= 1'b0;
         buffer_wr_ff <= 1'b0;
      end else begin
         reduced_power_ff <= rate_ff[`RATE_LOW_POWER_BIT];
         buffer_wr_ff <= sample_valid && (state_ff != ST_STANDBY);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_pc_write;
      acc_wr && reg_addr == `PWR_CTL_ADDR;
   endsequence
   sequence s_pc_read;
      acc_rd && !acc_wr && reg_addr == `PWR_CTL_ADDR;
   endsequence

   a_powerup_standby: assert property ($past(!rst_n) |-> state_ff == ST_STANDBY && !sensing_on_ff)
      else $error("not in standby after reset");
   a_measure_entry: assert property (state_ff == ST_STANDBY && measure_bit
      |=> state_ff == ST_MEASURE && sensing_on_ff)
      else $error("measure bit did not start measurement");
   a_standby_return: assert property (state_ff != ST_STANDBY && !measure_bit
      |=> state_ff == ST_STANDBY && !sensing_on_ff && !asleep_ff)
      else $error("measure cleared without standby");
   a_reg_readback: assert property (s_pc_write ##1 !acc_wr ##1 s_pc_read
      |=> reg_rvalid_ff && reg_rdata_ff == $past(reg_wdata, 3))
      else $error("power_control readback mismatch");
   a_low_power_skip: assert property (tick_io.odr_tick && rate_ff[`RATE_LOW_POWER_BIT] && !lp_phase_ff
      && state_ff != ST_STANDBY |=> !sample_req_ff)
      else $error("sample requested on skipped tick");
   a_timer_restart: assert property (armed && active_sample
      |=> sec_cnt_ff == 24'h000000 && quiet_secs_ff == 8'h00)
      else $error("inactivity timer not restarted");
   a_auto_sleep: assert property (timeout && measure_bit |=> state_ff == ST_SLEEP && asleep_ff)
      else $error("timeout did not enter sleep");
   a_measure_bit_pos: assert property ((s_pc_write and !reg_wdata[`PWR_MEASURE_BIT])
      |=> ##1 state_ff == ST_STANDBY)
      else $error("clearing bit 3 did not enter standby");
   a_buffer_frozen: assert property (state_ff == ST_STANDBY |=> !buffer_wr_ff)
      else $error("buffer written in standby");
endmodule
`default_nettype wire

// ===== sim/host_port_model.sv
/*
 Host side of the byte register port: single byte writes and reads.
 Assumes the device shares sys_clk and answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
   input wire logic sys_clk,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output accel_power_pkg::reg_byte_t reg_addr,
   output accel_power_pkg::reg_byte_t reg_wdata,
   input wire accel_power_pkg::reg_byte_t reg_rdata_ff,
   input wire logic reg_rvalid_ff
);
   import accel_power_pkg::*;
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Released lines show the inverse value
   task automatic wr(input reg_byte_t a, input reg_byte_t d);
      @(posedge sys_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input reg_byte_t a, output reg_byte_t d, output logic v);
      @(posedge sys_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata_ff;
      v = reg_rvalid_ff;
   endtask
endmodule
`default_nettype wire

// ===== sim/test_accel_power_mode_control.sv
/*
 Self-checking bench for the power mode controller.
 Assumes host_port_model drives the register port; bench drives samples.
*/
`timescale 1ns/100ps
`default_nettype none
module test_accel_power_mode_control;
   import accel_power_pkg::*;
   localparam int SEC = 4;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic io_supply_ok = 1'b0;
   logic sample_valid = 1'b0;
   axis_t accel_x = 16'h0000;
   axis_t accel_y = 16'h0000;
   axis_t accel_z = 16'h0000;
   logic reg_wr_en, reg_rd_en, reg_rvalid_ff, rv;
   logic sensing_on_ff, asleep_ff, reduced_power_ff, sample_req_ff, buffer_wr_ff;
   reg_byte_t reg_addr, reg_wdata, reg_rdata_ff, rb;
   reg_byte_t dad [4] = '{8'h25, 8'h26, 8'h2C, 8'h2D};
   reg_byte_t dval [4] = '{8'h00, 8'h00, 8'h0A, 8'h00};
   reg_byte_t rc [2] = '{8'h0E, 8'h0F};
   int per [2] = '{6250, 3125};
   int fail_count = 0;
   int total_checks = 0;
   int n;
   always #50 sys_clk = ~sys_clk;
   accel_power_mode_control #(.SEC_CYCLES(SEC)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .io_supply_ok(io_supply_ok), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff), .sample_valid(sample_valid), .accel_x(accel_x),
      .accel_y(accel_y), .accel_z(accel_z), .sensing_on_ff(sensing_on_ff), .asleep_ff(asleep_ff),
      .reduced_power_ff(reduced_power_ff), .sample_req_ff(sample_req_ff), .buffer_wr_ff(buffer_wr_ff));
   host_port_model i_host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_byte(input string s, input reg_byte_t e, input reg_byte_t g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic chk_bit(input string s, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %b got %b", s, e, g);
      end
   endtask
   task automatic chk_cnt(input string s, input int lo, input int hi, input int g);
      total_checks++;
      if (g < lo || g > hi) begin
         fail_count++;
         $display("[ERR] %s exp %0d..%0d got %0d", s, lo, hi, g);
      end
   endtask
   task automatic rdchk(input string s, input reg_byte_t a, input reg_byte_t e);
      i_host.rd(a, rb, rv);
      chk_bit(s, 1'b1, rv);
      chk_byte(s, e, rb);
   endtask
   task automatic smp(input axis_t x, input axis_t y, input axis_t z);
      @(posedge sys_clk);
      sample_valid <= 1'b1;
      accel_x <= x;
      accel_y <= y;
      accel_z <= z;
      @(posedge sys_clk);
      sample_valid <= 1'b0;
      accel_x <= ~x;
      accel_y <= ~y;
      accel_z <= ~z;
      #1;
   endtask
   task automatic wait_req(input int lim, output int c);
      c = 0;
      do begin
         @(posedge sys_clk);
         #1;
         c++;
      end while (sample_req_ff !== 1'b1 && c < lim);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (95000) @(posedge sys_clk);
      fail_count++;
      $display("[ERR] watchdog exp done got hang");
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      chk_bit("sensing", 1'b0, sensing_on_ff);
      i_host.wr(8'h25, 8'h55);
      i_host.rd(8'h25, rb, rv);
      chk_bit("rv_off", 1'b0, rv);
      @(posedge sys_clk);
      io_supply_ok <= 1'b1;
      for (int i = 0; i < 4; i++)
         rdchk("dflt", dad[i], dval[i]);
      i_host.wr(8'h26, 8'h03);
      i_host.wr(8'h10, 8'h77);
      rdchk("time", 8'h26, 8'h03);
      rdchk("unmap", 8'h10, 8'h00);
      i_host.wr(8'h2D, 8'h30);
      rdchk("pwr", 8'h2D, 8'h30);
      $display("power-up test done");
      for (int i = 0; i < 2; i++) begin
         i_host.wr(8'h2C, rc[i]);
         i_host.wr(8'h2D, 8'h08);
         wait_req(8000, n);
         wait_req(8000, n);
         chk_cnt("period", per[i], per[i], n);
         chk_bit("lowpwr", 1'b0, reduced_power_ff);
         i_host.wr(8'h2D, 8'h00);
      end
      wait_req(4000, n);
      chk_cnt("idle", 4000, 4000, n);
      i_host.wr(8'h2C, 8'h1C);
      i_host.wr(8'h2D, 8'h08);
      chk_bit("lowpwr", 1'b1, reduced_power_ff);
      wait_req(60000, n);
      chk_cnt("lp_first", 49999, 50005, n);
      i_host.wr(8'h2D, 8'h00);
      $display("rate test done");
      i_host.wr(8'h2D, 8'h08);
      #1;
      chk_bit("sens_early", 1'b0, sensing_on_ff);
      @(posedge sys_clk);
      #1;
      chk_bit("sensing", 1'b1, sensing_on_ff);
      rdchk("status", 8'h3F, 8'h01);
      smp(16'h0064, 16'h0000, 16'h0000);
      chk_bit("bufwr", 1'b1, buffer_wr_ff);
      i_host.wr(8'h2D, 8'h00);
      @(posedge sys_clk);
      #1;
      chk_bit("sensing", 1'b0, sensing_on_ff);
      smp(16'h0064, 16'h0000, 16'h0000);
      chk_bit("bufwr", 1'b0, buffer_wr_ff);
      $display("measure test done");
      i_host.wr(8'h25, 8'h03);
      i_host.wr(8'h26, 8'h03);
      i_host.wr(8'h2D, 8'h38);
      repeat (4) smp(16'h0030, 16'hFFD0, 16'h0030);
      chk_bit("asleep", 1'b0, asleep_ff);
      repeat (4) smp(16'h0030, 16'hFFD0, 16'h0030);
      chk_bit("asleep", 1'b1, asleep_ff);
      rdchk("status", 8'h3F, 8'h03);
      smp(16'h0000, 16'h0000, 16'hFF9C);
      @(posedge sys_clk);
      #1;
      chk_bit("asleep", 1'b0, asleep_ff);
      repeat (6) begin
         smp(16'h0000, 16'h0064, 16'h0000);
         repeat (2) smp(16'h0000, 16'h0000, 16'h0000);
      end
      chk_bit("asleep", 1'b0, asleep_ff);
      repeat (8) smp(16'h0000, 16'h0000, 16'h0000);
      chk_bit("asleep", 1'b1, asleep_ff);
      i_host.wr(8'h2D, 8'h08);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_bit("asleep", 1'b0, asleep_ff);
      i_host.wr(8'h2D, 8'h00);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_bit("sensing", 1'b0, sensing_on_ff);
      $display("sleep test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
